// file: rtl/line_thermal_function.v
// Contract
// RULE1: each step update model, compare thresholds
// RULE2: model input is largest phase rms
// RULE3: sensor ambient only when sensor present
// RULE4: off mode keeps all outputs low; here alarm, trip and lock go low, computed_temp_value still updates
// RULE5: pulsed mode gives one-step trip pulse; here the trip pulse lasts one clock, not a whole step
// RULE6: locked trip holds until below unlock
// RULE7: separate alarm output
// RULE8: general trip output follows mode
// RULE9: reclose lock output blocks reclosing
// RULE10: block input disables whole function; here alarm, trip and lock go low while the model and temperature keep updating
// RULE11: heat reset clears accumulated heat
// RULE12: heat reset used only for testing
// RULE13: level = (1-a)*prev + a*i2/in2
// RULE14: temperature = rise plus ambient
// RULE15: alarm while above alarm setting
// RULE16: computed temperature output every step
`timescale 1ns/1ps
`include "thermal_consts.vh"
module line_thermal_function (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [15:0] rms_l1,
    input wire [15:0] rms_l2,
    input wire [15:0] rms_l3,
    input wire [15:0] ambient_sensor_in,
    input wire function_block_in,
    input wire heat_reset_in,
    output reg thermal_alarm_out,
    output reg thermal_trip_out,
    output reg reclose_lock_out,
    output reg [15:0] computed_temp_value,
    output reg irq
);
    // block and heat reset pins pass two flops first; phase rms and sensor inputs are used directly
    reg [1:0] blk_s_q;
    reg [1:0] rst_s_q;
    // registers
    reg [31:0] ctrl_q;
    reg [15:0] alarm_temp_setting;
    reg [15:0] trip_temp_setting;
    reg [15:0] unlock_temp_setting;
    reg [15:0] fixed_ambient_setting;
    reg [15:0] rated_rise_q;
    reg [15:0] rated_cur_q;
    reg [15:0] alpha_q;
    reg [31:0] step_div_q;
    reg [31:0] step_cnt_q;
    reg [31:0] level_q;
    reg lock_q;
    reg [`NEV-1:0] irq_stat_q;
    reg [`NEV-1:0] irq_mask_q;
    reg [`NEV-1:0] ev_prev_q;
    // ahb address phase capture
    reg wr_pend_q;
    reg rd_pend_q;
    reg [11:0] addr_q;

    wire [1:0] thermal_operating_mode;
    wire ambient_sensor_present;
    assign thermal_operating_mode = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign ambient_sensor_present = ctrl_q[`CTRL_SENSOR];

    wire blk;
    wire hrst;
    assign blk = blk_s_q[1];
    assign hrst = rst_s_q[1];

    // largest of the three phase currents
    wire [15:0] max12;
    wire [15:0] imax;
    assign max12 = (rms_l1 > rms_l2) ? rms_l1 : rms_l2; // [RULE2]
    assign imax = (max12 > rms_l3) ? max12 : rms_l3; // [RULE2]

    // (i/in)^2 in Q16; divider is combinational, slow but one step is long
    wire [31:0] isq;
    wire [31:0] insq;
    wire [47:0] ratio;
    assign isq = imax * imax;
    assign insq = (rated_cur_q == 16'h0000) ? 32'h00000001 :
        rated_cur_q * rated_cur_q;
    assign ratio = {isq, 16'h0000} / {16'h0000, insq};
    wire [31:0] ratio_sat;
    assign ratio_sat = (ratio[47:32] != 16'h0000) ? 32'hffffffff :
        ratio[31:0];

    // first order update of the relative level
    wire [31:0] one_m_a;
    wire [63:0] keep_p;
    wire [63:0] gain_p;
    wire [63:0] lvl_sum;
    wire [31:0] level_d;
    assign one_m_a = `ONE_Q - {16'h0000, alpha_q};
    assign keep_p = level_q * one_m_a; // [RULE13]
    assign gain_p = ratio_sat * {16'h0000, alpha_q}; // [RULE13]
    assign lvl_sum = (keep_p + gain_p) >> `FRAC; // [RULE13]
    assign level_d = (lvl_sum[63:32] != 32'h00000000) ? 32'hffffffff :
        lvl_sum[31:0];

    // temperature = level * rated rise + ambient
    wire [15:0] amb;
    wire [47:0] rise_p;
    wire [31:0] rise_w;
    wire [31:0] temp_w;
    wire [15:0] temp_now;
    assign amb = ambient_sensor_present ? ambient_sensor_in :
        fixed_ambient_setting; // [RULE3]
    assign rise_p = level_q * rated_rise_q;
    assign rise_w = rise_p[47:16];
    assign temp_w = rise_w + {16'h0000, amb}; // [RULE14]
    assign temp_now = (temp_w[31:16] != 16'h0000) ? 16'hffff :
        temp_w[15:0];

    wire step;
    wire active;
    assign step = (step_cnt_q == 32'h00000000);
    assign active = (thermal_operating_mode != `MODE_OFF) && !blk;

    wire [`NEV-1:0] ev_now;
    assign ev_now = {reclose_lock_out, thermal_trip_out, thermal_alarm_out};
    wire [`NEV-1:0] ev_rise;
    assign ev_rise = ev_now & ~ev_prev_q;

    wire addr_ok;
    assign addr_ok = hsel && hready && htrans[1];
    wire rd_stat;
    assign rd_stat = rd_pend_q && (addr_q == `OFF_IRQ_STAT);
    // a new divider restarts the step timer, no wait on the old count
    wire div_wr;
    assign div_wr = wr_pend_q && (addr_q == `OFF_STEP_DIV);
    // a read clears only the bits it reported; later rises survive
    wire [`NEV-1:0] stat_clr;
    wire [`NEV-1:0] stat_d;
    assign stat_clr = rd_stat ? hrdata[`NEV-1:0] : {`NEV{1'b0}};
    assign stat_d = (irq_stat_q & ~stat_clr) | ev_rise;

    // synchronisers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blk_s_q <= 2'h0;
            rst_s_q <= 2'h0;
        end else if (clk_en) begin
            blk_s_q <= {blk_s_q[0], function_block_in};
            rst_s_q <= {rst_s_q[0], heat_reset_in};
        end
    end

    // step timer, model and decision
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_cnt_q <= 32'h00000000;
            level_q <= 32'h00000000;
            lock_q <= 1'b0;
            thermal_alarm_out <= 1'b0;
            thermal_trip_out <= 1'b0;
            reclose_lock_out <= 1'b0;
            computed_temp_value <= 16'h0000;
        end else if (clk_en) begin
            if (div_wr)
                step_cnt_q <= 32'h00000000;
            else
                step_cnt_q <= step ? step_div_q : step_cnt_q - 32'h00000001;
            if (step) begin
                // heat reset overrides the update; model restarts cold
                if (hrst)
                    level_q <= 32'h00000000; // [RULE11]
                else
                    level_q <= level_d; // [RULE1]
                computed_temp_value <= temp_now; // [RULE16]
                if (!active) begin
                    // off or blocked: every status low [RULE4] [RULE10]
                    lock_q <= 1'b0;
                    thermal_alarm_out <= 1'b0;
                    thermal_trip_out <= 1'b0;
                    reclose_lock_out <= 1'b0;
                end else begin
                    thermal_alarm_out <=
                        (temp_now > alarm_temp_setting); // [RULE15] [RULE7]
                    if (thermal_operating_mode == `MODE_LOCKED) begin
                        if (temp_now > trip_temp_setting)
                            lock_q <= 1'b1; // [RULE6]
                        else if (temp_now < unlock_temp_setting)
                            lock_q <= 1'b0; // [RULE6]
                        thermal_trip_out <= (temp_now > trip_temp_setting)
                            || (lock_q &&
                            !(temp_now < unlock_temp_setting)); // [RULE8]
                        reclose_lock_out <= (temp_now > trip_temp_setting)
                            || (lock_q &&
                            !(temp_now < unlock_temp_setting)); // [RULE9]
                    end else begin
                        // pulse on crossing; lock tracks heat until cool
                        if (temp_now > trip_temp_setting)
                            lock_q <= 1'b1;
                        else if (temp_now < unlock_temp_setting)
                            lock_q <= 1'b0;
                        thermal_trip_out <= (temp_now > trip_temp_setting)
                            && !lock_q; // [RULE5] [RULE8]
                        reclose_lock_out <= (temp_now > trip_temp_setting)
                            || (lock_q &&
                            !(temp_now < unlock_temp_setting)); // [RULE9]
                    end
                end
            end else begin
                // pulse lasts one clock; the spare mode code acts pulsed
                if (thermal_operating_mode != `MODE_LOCKED)
                    thermal_trip_out <= 1'b0; // [RULE5]
            end
        end
    end

    // ahb-lite slave, zero wait states, okay only
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            ctrl_q <= `RST_CTRL;
            alarm_temp_setting <= `RST_ALARM;
            trip_temp_setting <= `RST_TRIP;
            unlock_temp_setting <= `RST_UNLOCK;
            fixed_ambient_setting <= `RST_AMB;
            rated_rise_q <= `RST_RATED;
            rated_cur_q <= `RST_RATEDCUR;
            alpha_q <= `RST_ALPHA;
            step_div_q <= `RST_STEP_DIV;
            irq_stat_q <= {`NEV{1'b0}};
            irq_mask_q <= {`NEV{1'b0}};
            ev_prev_q <= {`NEV{1'b0}};
            irq <= 1'b0;
        end else if (clk_en) begin
            wr_pend_q <= addr_ok && hwrite;
            rd_pend_q <= addr_ok && !hwrite;
            if (addr_ok)
                addr_q <= {haddr[11:2], 2'h0};
            if (wr_pend_q) begin
                if (addr_q == `OFF_CTRL)
                    ctrl_q <= hwdata;
                else if (addr_q == `OFF_ALARM)
                    alarm_temp_setting <= hwdata[15:0];
                else if (addr_q == `OFF_TRIP)
                    trip_temp_setting <= hwdata[15:0];
                else if (addr_q == `OFF_UNLOCK)
                    unlock_temp_setting <= hwdata[15:0];
                else if (addr_q == `OFF_AMB)
                    fixed_ambient_setting <= hwdata[15:0];
                else if (addr_q == `OFF_RATED)
                    rated_rise_q <= hwdata[15:0];
                else if (addr_q == `OFF_RATEDCUR)
                    rated_cur_q <= hwdata[15:0];
                else if (addr_q == `OFF_ALPHA)
                    alpha_q <= hwdata[15:0];
                else if (addr_q == `OFF_IRQ_MASK)
                    irq_mask_q <= hwdata[`NEV-1:0];
                else if (addr_q == `OFF_STEP_DIV)
                    step_div_q <= hwdata;
            end
            // read data is muxed in the address phase
            if (addr_ok && !hwrite) begin
                if (haddr[11:0] == `OFF_CTRL)
                    hrdata <= ctrl_q;
                else if (haddr[11:0] == `OFF_ALARM)
                    hrdata <= {16'h0000, alarm_temp_setting};
                else if (haddr[11:0] == `OFF_TRIP)
                    hrdata <= {16'h0000, trip_temp_setting};
                else if (haddr[11:0] == `OFF_UNLOCK)
                    hrdata <= {16'h0000, unlock_temp_setting};
                else if (haddr[11:0] == `OFF_AMB)
                    hrdata <= {16'h0000, fixed_ambient_setting};
                else if (haddr[11:0] == `OFF_RATED)
                    hrdata <= {16'h0000, rated_rise_q};
                else if (haddr[11:0] == `OFF_RATEDCUR)
                    hrdata <= {16'h0000, rated_cur_q};
                else if (haddr[11:0] == `OFF_ALPHA)
                    hrdata <= {16'h0000, alpha_q};
                else if (haddr[11:0] == `OFF_TEMP)
                    hrdata <= {16'h0000, computed_temp_value};
                else if (haddr[11:0] == `OFF_STATUS)
                    hrdata <= {29'h0, ev_now};
                else if (haddr[11:0] == `OFF_IRQ_STAT)
                    hrdata <= {29'h0, irq_stat_q};
                else if (haddr[11:0] == `OFF_IRQ_MASK)
                    hrdata <= {29'h0, irq_mask_q};
                else if (haddr[11:0] == `OFF_STEP_DIV)
                    hrdata <= step_div_q;
                else
                    hrdata <= 32'h00000000;
            end
            // sticky events: a new rise wins over the read clear
            ev_prev_q <= ev_now;
            irq_stat_q <= stat_d;
            irq <= |(stat_d & irq_mask_q);
        end
    end
endmodule

// file: include/thermal_consts.vh
`ifndef THERMAL_CONSTS_VH
`define THERMAL_CONSTS_VH
// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_ALARM 12'h004
`define OFF_TRIP 12'h008
`define OFF_UNLOCK 12'h00c
`define OFF_AMB 12'h010
`define OFF_RATED 12'h014
`define OFF_RATEDCUR 12'h018
`define OFF_ALPHA 12'h01c
`define OFF_TEMP 12'h020
`define OFF_STATUS 12'h024
`define OFF_IRQ_STAT 12'h028
`define OFF_IRQ_MASK 12'h02c
`define OFF_STEP_DIV 12'h030
// ctrl fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_SENSOR 2
// operating modes
`define MODE_OFF 2'h0
`define MODE_PULSED 2'h1
`define MODE_LOCKED 2'h2
// reset values
`define RST_CTRL 32'h00000001
`define RST_ALARM 16'h0050
`define RST_TRIP 16'h0064
`define RST_UNLOCK 16'h003c
`define RST_AMB 16'h0019
`define RST_RATED 16'h0064
`define RST_RATEDCUR 16'h0064
`define RST_ALPHA 16'h0010
`define RST_STEP_DIV 32'h0001e848
// fixed point: level has 16 fraction bits, alpha is step/T in 2^-16
`define FRAC 16
`define ONE_Q 32'h00010000
// event bits
`define EV_ALARM 0
`define EV_TRIP 1
`define EV_LOCK 2
`define NEV 3
`endif

// file: bench/upstream_model.sv
`timescale 1ns/1ps
module upstream_model (
    input wire hclk,
    output logic [15:0] rms_l1,
    output logic [15:0] rms_l2,
    output logic [15:0] rms_l3,
    output logic [15:0] ambient_sensor_in,
    output logic function_block_in,
    output logic heat_reset_in
);
    // no load, no block, no heat reset at time zero
    initial begin
        {rms_l1, rms_l2, rms_l3} = 48'h0;
        ambient_sensor_in = 16'h0;
        {function_block_in, heat_reset_in} = 2'h0;
    end
    // phases and user logic move together, just after an edge
    task drive(input logic [15:0] a, b, c, t, input logic k, r);
        @(posedge hclk);
        {rms_l1, rms_l2, rms_l3} <= {a, b, c};
        ambient_sensor_in <= t;
        function_block_in <= k;
        heat_reset_in <= r;
    endtask
endmodule

// file: bench/thermal_checker_asserts.sv
`timescale 1ns/1ps
module thermal_checker (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire function_block_in,
    input wire heat_reset_in,
    input wire thermal_alarm_out,
    input wire thermal_trip_out,
    input wire reclose_lock_out,
    input wire [15:0] computed_temp_value
);
    reg [5:0] blk_q;
    reg [5:0] hr_q;
    wire rd_go = hsel && hready && htrans[1] && !hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // hold lengths; saturate so a long hold stays seen
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blk_q <= 6'h0;
            hr_q <= 6'h0;
        end else begin
            blk_q <= function_block_in ? blk_q + {5'h0, ~&blk_q} : 6'h0;
            hr_q <= heat_reset_in ? hr_q + {5'h0, ~&hr_q} : 6'h0;
        end
    end
    a_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
    a_ready_high: assert property (hreadyout) else $error("wait state");
    a_rdata_hold: assert property (!rd_go |=> $stable(hrdata))
        else $error("hrdata moved");
    a_trip_lock: assert property (thermal_trip_out |-> reclose_lock_out)
        else $error("trip without lock");
    a_lock_fall: assert property ($fell(reclose_lock_out) |-> !thermal_trip_out)
        else $error("trip past lock");
    // sync plus one step period fits in 16 cycles
    a_block_quiet: assert property (blk_q > 6'd15 |->
        !(thermal_alarm_out || thermal_trip_out || reclose_lock_out))
        else $error("output while blocked");
    a_heat_cool: assert property (hr_q > 6'd29 |-> !thermal_trip_out)
        else $error("trip in heat reset");
    a_heat_flat: assert property (hr_q > 6'd29 |-> $stable(computed_temp_value))
        else $error("temp moved in reset");
    c_trip: cover property ($rose(thermal_trip_out));
    c_alarm: cover property ($rose(thermal_alarm_out));
    c_block: cover property (blk_q > 6'd15);
endmodule
bind line_thermal_function thermal_checker i_thermal_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .function_block_in(function_block_in), .heat_reset_in(heat_reset_in),
    .thermal_alarm_out(thermal_alarm_out),
    .thermal_trip_out(thermal_trip_out),
    .reclose_lock_out(reclose_lock_out),
    .computed_temp_value(computed_temp_value));

// file: bench/line_thermal_function_bench.sv
`timescale 1ns/1ps
`include "thermal_consts.vh"
module line_thermal_function_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic clk_en = 1'b1;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, alm, trp, lck, blk, hrst;
    wire [15:0] l1, l2, l3, amb, temp;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    initial forever #4 hclk = ~hclk;
    line_thermal_function i_line_thermal_function (.hclk(hclk),
        .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rms_l1(l1), .rms_l2(l2), .rms_l3(l3),
        .ambient_sensor_in(amb), .function_block_in(blk),
        .heat_reset_in(hrst), .thermal_alarm_out(alm),
        .thermal_trip_out(trp), .reclose_lock_out(lck),
        .computed_temp_value(temp), .irq(irq));
    upstream_model i_upstream_model (.hclk(hclk), .rms_l1(l1), .rms_l2(l2),
        .rms_l3(l3), .ambient_sensor_in(amb), .function_block_in(blk),
        .heat_reset_in(hrst));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one single word transfer; the bench's timeout ends a hang
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 20'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task t_regs;
        bus(0, `OFF_CTRL, 0);
        check(rd, `RST_CTRL);
        bus(0, `OFF_TRIP, 0);
        check(rd, {16'h0, `RST_TRIP});
        bus(0, `OFF_AMB, 0);
        check(rd, {16'h0, `RST_AMB});
        bus(0, 12'h040, 0);
        check(rd, 32'h0);
        // short steps and a fast time constant keep the run brief
        bus(1, `OFF_STEP_DIV, 32'ha);
        bus(1, `OFF_ALPHA, 32'h4000);
        bus(0, `OFF_ALPHA, 0);
        check(rd, 32'h4000);
    endtask
    task t_model;
        int n;
        bus(1, `OFF_CTRL, 32'h5);
        i_upstream_model.drive(16'd10, 16'd100, 16'd50, 16'd33, 0, 1);
        repeat (40) @(posedge hclk);
        check(temp, 16'd33);
        i_upstream_model.drive(16'd10, 16'd100, 16'd50, 16'd33, 0, 0);
        for (n = 0; n < 40 && temp === 16'd33; n++) @(posedge hclk);
        // one step at rated current adds a quarter of 100 deg
        check(temp, 16'd58);
    endtask
    task t_pulse;
        int hi;
        logic a;
        bus(1, `OFF_CTRL, 32'h1);
        i_upstream_model.drive(0, 0, 0, 16'd33, 0, 1);
        repeat (40) @(posedge hclk);
        check(temp, 16'd25);
        bus(0, `OFF_IRQ_STAT, 0);
        i_upstream_model.drive(16'd200, 0, 0, 16'd33, 0, 0);
        hi = 0;
        repeat (300) begin
            @(posedge hclk);
            hi += (trp === 1'b1);
        end
        check(hi, 1);
        check({alm, lck}, 2'h3);
        // mask polarity aside, the two settings must differ
        bus(1, `OFF_IRQ_MASK, 0);
        repeat (2) @(posedge hclk);
        a = irq;
        bus(1, `OFF_IRQ_MASK, 32'h7);
        repeat (2) @(posedge hclk);
        check(a ^ irq, 1'b1);
        bus(0, `OFF_IRQ_STAT, 0);
        check(rd, 32'h7);
        bus(0, `OFF_IRQ_STAT, 0);
        check(rd, 32'h0);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
    endtask
    task t_locked;
        int n;
        bus(1, `OFF_CTRL, 32'h2);
        i_upstream_model.drive(0, 0, 0, 0, 0, 1);
        repeat (40) @(posedge hclk);
        i_upstream_model.drive(0, 16'd200, 0, 0, 0, 0);
        repeat (300) @(posedge hclk);
        check(trp, 1'b1);
        i_upstream_model.drive(0, 0, 0, 0, 0, 0);
        repeat (22) @(posedge hclk);
        check(trp, 1'b1);
        // below trip but still above unlock the trip must hold
        for (n = 0; n < 200 && temp > 16'h0064; n++) @(posedge hclk);
        check(trp, 1'b1);
        check(temp > 16'h003c, 1'b1);
        repeat (400) @(posedge hclk);
        check({trp, lck}, 2'h0);
    endtask
    task t_block;
        bus(1, `OFF_CTRL, 32'h1);
        i_upstream_model.drive(0, 0, 16'd200, 0, 1, 0);
        repeat (300) @(posedge hclk);
        check({alm, trp, lck}, 3'h0);
        i_upstream_model.drive(0, 0, 16'd200, 0, 0, 0);
        repeat (300) @(posedge hclk);
        check({alm, lck}, 2'h3);
        bus(1, `OFF_CTRL, 32'h0);
        repeat (40) @(posedge hclk);
        check({alm, trp, lck}, 3'h0);
    endtask
    // clock enable low must freeze a model that is heating up
    task t_hold;
        int n;
        logic [15:0] t0;
        i_upstream_model.drive(0, 0, 0, 0, 0, 1);
        repeat (40) @(posedge hclk);
        i_upstream_model.drive(16'h00c8, 0, 0, 0, 0, 0);
        for (n = 0; n < 40 && temp === 16'h0019; n++) @(posedge hclk);
        clk_en <= 1'b0;
        @(posedge hclk);
        t0 = temp;
        repeat (40) @(posedge hclk);
        check(temp, t0);
        clk_en <= 1'b1;
        repeat (40) @(posedge hclk);
        check(temp != t0, 1'b1);
    endtask
    // a hung wait counts as a mismatch
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            close_out;
        end
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_model;
        t_pulse;
        t_locked;
        t_hold;
        t_block;
        close_out;
    end
endmodule
